// File: spw_pkg.sv
// spw_pkg: register map, field positions and reset values of the wake status block
// assumes a 32-bit AHB-Lite slave with one aligned word per register
package spw_pkg;
  // ==========================================================================
  // register indices as printed, byte address is four times the index
  localparam logic [7:0]  STS1_IDX   = 8'hb2;
  localparam logic [7:0]  STS2_IDX   = 8'hb3;
  localparam logic [7:0]  EN1_IDX    = 8'hb0;
  localparam logic [7:0]  EN2_IDX    = 8'hb1;
  localparam logic [7:0]  MASK1_IDX  = 8'hc8;
  localparam logic [7:0]  MASK2_IDX  = 8'hc9;
  localparam logic [7:0]  ISTS1_IDX  = 8'hca;
  localparam logic [7:0]  ISTS2_IDX  = 8'hcb;
  localparam int          ADDR_W     = 12;
  // ==========================================================================
  // reset values
  localparam logic [7:0]  STS_RST    = 8'h00;
  localparam logic [7:0]  EN1_RST    = 8'h00;
  localparam logic [7:0]  EN2_RST    = 8'h80;
  localparam logic [7:0]  MASK_RST   = 8'h00;
  // ==========================================================================
  // field positions of status 1
  localparam int          S1_RI1     = 0;
  localparam int          S1_RI2     = 1;
  localparam int          S1_KEYBOARD_CLOCK_WAKE_SEEN    = 2;
  localparam int          S1_MCLK    = 3;
  localparam int          S1_GRP1    = 4;
  localparam int          S1_GRP2    = 5;
  localparam int          S1_IR2     = 6;
  localparam int          S1_ALARM   = 7;
  // field positions of status 2
  localparam int          S2_RX1     = 0;
  localparam int          S2_RX2     = 1;
  localparam int          S2_BUTTON  = 2;
  localparam int          S2_RING    = 3;
  localparam int          S2_CIR     = 5;
  // implemented bits of status 2, the rest reserved
  localparam logic [7:0]  S2_USED    = 8'h2f;
  // bits of status 2 that may request power-on (button excluded)
  localparam logic [7:0]  S2_WAKE    = 8'h2b;
  // number of pin inputs needing edge detection
  localparam int          NPIN       = 9;
  // ==========================================================================
  // bus encodings
  localparam logic [1:0]  HTRANS_NSQ = 2'b10;
  localparam logic [31:0] ZERO_WORD  = 32'h0000_0000;
endpackage

// File: spw_edge.sv
// spw_edge: two-flop synchroniser per pin plus falling edge pulse
// assumes asynchronous pins, pins idle high
`timescale 1ns/1ns
module spw_edge #(
  parameter int N = 9
) (
  input  wire logic         CLK,
  input  wire logic         NRST,
  input  wire logic [N-1:0] PIN_IN,
  output logic      [N-1:0] FALL
);
  logic [N-1:0] meta_ff;
  logic [N-1:0] sync_ff;
  logic [N-1:0] last_ff;

  // ==========================================================================
  // synchronise then compare with previous sample
  // (R14) sync before edge
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      meta_ff <= '1;
      sync_ff <= '1;
      last_ff <= '1;
    end else begin
      meta_ff <= PIN_IN;
      sync_ff <= meta_ff;
      last_ff <= sync_ff;
    end
  end

  assign FALL = last_ff & ~sync_ff;
endmodule // spw_edge

// File: spw_wake_status.sv
// spw_wake_status: soft power wake event status registers with AHB-Lite access
// assumes NRST is the battery-supply power-on reset, pins asynchronous and idle high
//
// Notes on behaviour
// (R1) a status bit reads 1 once its event occurred since last clear, else 0
// (R2) status 1 bits 0,1 latch falling edges of port 1 and 2 ring inputs
// (R3) status 1 bits 2,3 latch falling edges of keyboard and mouse clocks
// (R4) status 1 bit 6 latches falling edge on second infrared receive input
// (R5) status 1 bit 7 latches the internal alarm signal, cleared on read
// (R6) latched events are held and serve as power-on wake sources
// (R7) status 1 bits 4,5 show live group interrupt levels, not latched
// (R8) status 2 bits 0,1 latch falling edges on port receive data pins
// (R9) status 2 bit 3 latches ring detect pin events, cleared on read
// (R10) status 2 bit 5 latches consumer infrared wake event, cleared on read
// (R11) status 2 bit 2 latches button press; never feeds power request
// (R12) status 2 bits 4,6,7 reserved, read zero
// (R13) a source requests power-on only when its enable bit is 1
// (R14) pins synchronised first; event during clearing read still captured
// (R15) writes to status registers leave latched bits unchanged
`timescale 1ns/1ns
module spw_wake_status
  import spw_pkg::*;
(
  input  wire logic        SYS_CLK,
  input  wire logic        NRST,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  input  wire logic        PORT1_RING_N,
  input  wire logic        PORT2_RING_N,
  input  wire logic        KEYBOARD_CLOCK,
  input  wire logic        MOUSE_CLOCK,
  input  wire logic        INFRARED2_RX,
  input  wire logic        PORT1_RX,
  input  wire logic        PORT2_RX,
  input  wire logic        RING_DETECT_PIN_N,
  input  wire logic        POWER_BUTTON_N,
  input  wire logic        RTC_ALARM,
  input  wire logic        GROUP_INTERRUPT_ONE,
  input  wire logic        GROUP_INTERRUPT_TWO,
  input  wire logic        CONSUMER_INFRARED_WAKE,
  output logic             SYSTEM_POWER_REQUEST_N,
  output logic             IRQ
);

  // ==========================================================================
  // pin edge detection
  logic [NPIN-1:0] pins;
  logic [NPIN-1:0] fall;

  assign pins = {POWER_BUTTON_N, RING_DETECT_PIN_N, PORT2_RX, PORT1_RX, INFRARED2_RX,
                 MOUSE_CLOCK, KEYBOARD_CLOCK, PORT2_RING_N, PORT1_RING_N};

  spw_edge #(
    .N (NPIN)
  ) u_edge (
    .CLK    (SYS_CLK),
    .NRST   (NRST),
    .PIN_IN (pins),
    .FALL   (fall)
  );

  // ==========================================================================
  // internal event signals are on this clock; alarm taken as rising event
  logic alarm_last_ff;
  logic cir_last_ff;
  logic alarm_rise;
  logic cir_rise;

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      alarm_last_ff <= 1'b0;
      cir_last_ff   <= 1'b0;
    end else begin
      alarm_last_ff <= RTC_ALARM;
      cir_last_ff   <= CONSUMER_INFRARED_WAKE;
    end
  end

  assign alarm_rise = RTC_ALARM & ~alarm_last_ff;
  assign cir_rise   = CONSUMER_INFRARED_WAKE & ~cir_last_ff;

  // ==========================================================================
  // event vectors in register layout
  logic [7:0] ev1;
  logic [7:0] ev2;

  // (R2) ring edges
  assign ev1[S1_RI1]   = fall[0];
  assign ev1[S1_RI2]   = fall[1];
  // (R3) keyboard mouse edges
  assign ev1[S1_KEYBOARD_CLOCK_WAKE_SEEN]  = fall[2];
  assign ev1[S1_MCLK]  = fall[3];
  // group bits hold no latch; their live level is merged into the status view
  assign ev1[S1_GRP1]  = 1'b0;
  assign ev1[S1_GRP2]  = 1'b0;
  // (R4) infrared edge
  assign ev1[S1_IR2]   = fall[4];
  // (R5) alarm event
  assign ev1[S1_ALARM] = alarm_rise;

  // (R8) receive edges
  assign ev2[S2_RX1]    = fall[5];
  assign ev2[S2_RX2]    = fall[6];
  // (R11) button latch
  assign ev2[S2_BUTTON] = fall[8];
  // (R9) ring pin edge
  assign ev2[S2_RING]   = fall[7];
  // (R10) consumer infrared event
  assign ev2[S2_CIR]    = cir_rise;
  // (R12) reserved bits zero
  assign ev2[4]         = 1'b0;
  assign ev2[7:6]       = 2'b00;

  // ==========================================================================
  // AHB-Lite address phase capture
  logic              ap_valid_ff;
  logic              ap_write_ff;
  logic [ADDR_W-1:0] ap_addr_ff;
  logic              take;

  assign take = HSEL & HREADY & HTRANS[1];

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      ap_valid_ff <= 1'b0;
      ap_write_ff <= 1'b0;
      ap_addr_ff  <= '0;
    end else begin
      ap_valid_ff <= take;
      ap_write_ff <= HWRITE;
      ap_addr_ff  <= HADDR[ADDR_W-1:0];
    end
  end

  // ==========================================================================
  // decode: reads in the address phase, writes in the data phase
  // read data is captured at the same edge that clears the read-to-clear bits,
  // so an event landing one cycle earlier is neither lost nor hidden
  logic [ADDR_W-3:0] idx;
  logic [ADDR_W-3:0] a_idx;
  logic              rd_take;
  logic              wr_phase;
  logic              hit_sts1;
  logic              hit_sts2;
  logic              hit_en1;
  logic              hit_en2;
  logic              hit_mask1;
  logic              hit_mask2;
  logic              hit_ists1;
  logic              hit_ists2;
  logic              wr_en1;
  logic              wr_en2;
  logic              wr_mask1;
  logic              wr_mask2;

  assign idx       = ap_addr_ff[ADDR_W-1:2];
  assign a_idx     = HADDR[ADDR_W-1:2];
  assign rd_take   = take & ~HWRITE;
  assign wr_phase  = ap_valid_ff & ap_write_ff;
  assign hit_sts1  = a_idx == {2'b00, STS1_IDX};
  assign hit_sts2  = a_idx == {2'b00, STS2_IDX};
  assign hit_en1   = a_idx == {2'b00, EN1_IDX};
  assign hit_en2   = a_idx == {2'b00, EN2_IDX};
  assign hit_mask1 = a_idx == {2'b00, MASK1_IDX};
  assign hit_mask2 = a_idx == {2'b00, MASK2_IDX};
  assign hit_ists1 = a_idx == {2'b00, ISTS1_IDX};
  assign hit_ists2 = a_idx == {2'b00, ISTS2_IDX};
  assign wr_en1    = wr_phase & (idx == {2'b00, EN1_IDX});
  assign wr_en2    = wr_phase & (idx == {2'b00, EN2_IDX});
  assign wr_mask1  = wr_phase & (idx == {2'b00, MASK1_IDX});
  assign wr_mask2  = wr_phase & (idx == {2'b00, MASK2_IDX});

  // ==========================================================================
  // wake status latches
  logic [7:0] sts1_ff;
  logic [7:0] sts2_ff;
  logic [7:0] nxt_sts1;
  logic [7:0] nxt_sts2;
  logic [7:0] clr1;
  logic [7:0] clr2;

  // (R15) only reads clear, writes ignored
  assign clr1 = {8{rd_take & hit_sts1}};
  assign clr2 = {8{rd_take & hit_sts2}};
  // (R14) set wins over read clear
  assign nxt_sts1 = (sts1_ff & ~clr1) | ev1;
  assign nxt_sts2 = ((sts2_ff & ~clr2) | ev2) & S2_USED;

  // (R6) hold latched events
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      sts1_ff <= STS_RST;
      sts2_ff <= STS_RST;
    end else begin
      sts1_ff <= nxt_sts1;
      sts2_ff <= nxt_sts2;
    end
  end

  // (R7) live group interrupt levels
  // (R1) status view
  logic [7:0] sts1_view;
  assign sts1_view = {sts1_ff[7:6], GROUP_INTERRUPT_TWO, GROUP_INTERRUPT_ONE, sts1_ff[3:0]};

  // ==========================================================================
  // enable and interrupt mask registers
  logic [7:0] en1_ff;
  logic [7:0] en2_ff;
  logic [7:0] mask1_ff;
  logic [7:0] mask2_ff;

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      en1_ff   <= EN1_RST;
      en2_ff   <= EN2_RST;
      mask1_ff <= MASK_RST;
      mask2_ff <= MASK_RST;
    end else begin
      if (wr_en1) en1_ff <= HWDATA[7:0];
      if (wr_en2) en2_ff <= HWDATA[7:0];
      if (wr_mask1) mask1_ff <= HWDATA[7:0];
      if (wr_mask2) mask2_ff <= HWDATA[7:0];
    end
  end

  // ==========================================================================
  // power-on request, button bit excluded
  logic wake;
  logic pwr_n_ff;

  // (R13) enable gates sources
  // (R11) button not in request
  // group levels enter live, so a held group interrupt keeps the request
  assign wake = |(sts1_view & en1_ff) | |(sts2_ff & en2_ff & S2_WAKE);

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) pwr_n_ff <= 1'b1;
    else pwr_n_ff <= ~wake;
  end

  assign SYSTEM_POWER_REQUEST_N = pwr_n_ff;

  // ==========================================================================
  // interrupt status, sticky, cleared by read
  logic [7:0] ists1_ff;
  logic [7:0] ists2_ff;
  logic [7:0] ev1_all;
  logic [7:0] ir_clr1;
  logic [7:0] ir_clr2;
  logic       irq_ff;

  assign ev1_all = ev1 | {2'b00, GROUP_INTERRUPT_TWO, GROUP_INTERRUPT_ONE, 4'h0};
  // cleared at the address phase of the read, like the wake status
  assign ir_clr1 = {8{rd_take & hit_ists1}};
  assign ir_clr2 = {8{rd_take & hit_ists2}};

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      ists1_ff <= STS_RST;
      ists2_ff <= STS_RST;
      irq_ff   <= 1'b0;
    end else begin
      ists1_ff <= (ists1_ff & ~ir_clr1) | ev1_all;
      ists2_ff <= (ists2_ff & ~ir_clr2) | ev2;
      irq_ff   <= |((ists1_ff & ~ir_clr1 | ev1_all) & mask1_ff)
                | |((ists2_ff & ~ir_clr2 | ev2) & mask2_ff);
    end
  end

  assign IRQ = irq_ff;

  // ==========================================================================
  // read data mux, unmapped reads zero
  logic [7:0] rd_byte;

  assign rd_byte = hit_sts1  ? sts1_view :
                   hit_sts2  ? sts2_ff   :
                   hit_en1   ? en1_ff    :
                   hit_en2   ? en2_ff    :
                   hit_mask1 ? mask1_ff  :
                   hit_mask2 ? mask2_ff  :
                   hit_ists1 ? ists1_ff  :
                   hit_ists2 ? ists2_ff  : 8'h00;

  logic [31:0] hrdata_ff;

  // read word registered at the address phase, zero outside a read data phase
  // a back-to-back read reloads it, so each data phase shows its own word
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) hrdata_ff <= ZERO_WORD;
    else if (rd_take) hrdata_ff <= {24'h000000, rd_byte};
    else hrdata_ff <= ZERO_WORD;
  end

  assign HRDATA    = hrdata_ff;
  assign HREADYOUT = 1'b1;
  assign HRESP     = 1'b0;
endmodule // spw_wake_status

// File: spw_chk.sv
// spw_chk: bus and status assertions for the wake status block
// assumes a zero wait slave and pins that idle high
`timescale 1ns/1ns
module spw_chk
  import spw_pkg::*;
(
  input wire logic        SYS_CLK,
  input wire logic        NRST,
  input wire logic        HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0]  HTRANS,
  input wire logic        HWRITE,
  input wire logic        HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic        HREADYOUT,
  input wire logic        HRESP,
  input wire logic        PORT1_RING_N,
  input wire logic        PORT2_RING_N,
  input wire logic        KEYBOARD_CLOCK,
  input wire logic        MOUSE_CLOCK,
  input wire logic        INFRARED2_RX,
  input wire logic        RTC_ALARM,
  input wire logic        GROUP_INTERRUPT_ONE,
  input wire logic        GROUP_INTERRUPT_TWO,
  input wire logic        SYSTEM_POWER_REQUEST_N,
  input wire logic        IRQ
);
  logic       rd_ff;
  logic [9:0] idx_ff;
  logic [3:0] quiet_ff;
  wire  [1:0] grp  = {GROUP_INTERRUPT_TWO, GROUP_INTERRUPT_ONE};
  wire        take = HSEL & HREADY & HTRANS[1];
  wire        calm = &{PORT1_RING_N, PORT2_RING_N, KEYBOARD_CLOCK,
                       MOUSE_CLOCK, INFRARED2_RX, ~RTC_ALARM};
  wire        rd1  = rd_ff & (idx_ff == {2'h0, STS1_IDX});
  wire        rd2  = rd_ff & (idx_ff == {2'h0, STS2_IDX});
  wire        map  = (idx_ff[9:8] == 2'h0) &
                     (idx_ff[7:0] inside {[EN1_IDX:STS2_IDX], [MASK1_IDX:ISTS2_IDX]});
  // data phase tracking and quiet span of the status 1 pins
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      rd_ff    <= 1'b0;
      idx_ff   <= 10'h0;
      quiet_ff <= 4'h0;
    end else begin
      rd_ff    <= take & ~HWRITE;
      idx_ff   <= take ? HADDR[11:2] : idx_ff;
      quiet_ff <= calm ? quiet_ff + {3'h0, ~&quiet_ff} : 4'h0;
    end
  end
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);
  // ==========================================================================
  // assertions
  chk_ready_high: assert property (HREADYOUT) else $error("hreadyout low");
  chk_resp_okay: assert property (!HRESP) else $error("hresp not okay");
  chk_idle_zero: assert property (!rd_ff |-> HRDATA == 32'h0) else $error("rdata not zero");
  chk_upper_zero: assert property (rd_ff |-> HRDATA[31:8] == 24'h0) else $error("upper bits set");
  chk_rsvd_zero:
    assert property (rd2 |-> (HRDATA[7:0] & ~S2_USED) == 8'h0) else $error("reserved bit set");
  chk_grp_live:
    assert property (rd1 && $stable(grp) |-> HRDATA[5:4] == grp) else $error("group bits wrong");
  chk_clear_read:
    assert property (rd1 && $past(rd1, 2) && quiet_ff > 4'h6 |->
      HRDATA[7:6] == 2'h0 && HRDATA[3:0] == 4'h0) else $error("latched bit not cleared");
  chk_unmapped_zero: assert property (rd_ff && !map |-> HRDATA == 32'h0) else $error("unmapped data");
  chk_reset_idle:
    assert property ($rose(NRST) |-> SYSTEM_POWER_REQUEST_N && !IRQ) else $error("busy after reset");
endmodule // spw_chk

// File: spw_src.sv
// spw_src: wake source model, one pin or internal event per request bit
// assumes FIRE is a one-cycle mask from the bench, pins idle high
`timescale 1ns/1ns
module spw_src (
  input  wire logic        SYS_CLK,
  input  wire logic [10:0] FIRE,
  output logic      [8:0]  PINS,
  output logic             ALARM,
  output logic             CIR
);
  logic [2:0] hold_ff [11] = '{default: 3'h0};
  // ==========================================================================
  // each event lasts four cycles: pin low, or internal signal high
  always_ff @(posedge SYS_CLK) begin
    for (int i = 0; i < 11; i++) begin
      hold_ff[i] <= FIRE[i] ? 3'h4 : hold_ff[i] - {2'h0, hold_ff[i] != 3'h0};
    end
  end
  always_comb begin
    for (int i = 0; i < 9; i++) begin
      PINS[i] = (hold_ff[i] == 3'h0);
    end
  end
  assign ALARM = (hold_ff[9] != 3'h0);
  assign CIR   = (hold_ff[10] != 3'h0);
endmodule // spw_src

// File: soft_power_wake_status_test.sv
// soft_power_wake_status_test: self-checking bench of the wake status block
// assumes a zero wait AHB-Lite slave and the source model spw_src
`timescale 1ns/1ns
module soft_power_wake_status_test;
  import spw_pkg::*;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic        g1 = 1'b0;
  logic        g2 = 1'b0;
  logic [10:0] fire = 11'h0;
  logic [8:0]  pins;
  logic        alarm, cir, hready, hresp, req_n, irq;
  logic [31:0] hrdata, rv;
  logic [7:0]  ri;
  int          err_total = 0;
  int          samples_checked = 0;
  // rows: status register, expected value, expected request level
  logic [10:0] rsel = 11'h5e0;
  logic [10:0] rreq = 11'h100;
  logic [7:0]  rexp [11] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h40, 8'h01,
                             8'h02, 8'h08, 8'h04, 8'h80, 8'h20};
  spw_wake_status spw_wake_status_inst (.SYS_CLK(clk), .NRST(nrst), .HSEL(1'b1),
    .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
    .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp),
    .PORT1_RING_N(pins[0]), .PORT2_RING_N(pins[1]), .KEYBOARD_CLOCK(pins[2]),
    .MOUSE_CLOCK(pins[3]), .INFRARED2_RX(pins[4]), .PORT1_RX(pins[5]), .PORT2_RX(pins[6]),
    .RING_DETECT_PIN_N(pins[7]), .POWER_BUTTON_N(pins[8]), .RTC_ALARM(alarm),
    .GROUP_INTERRUPT_ONE(g1), .GROUP_INTERRUPT_TWO(g2), .CONSUMER_INFRARED_WAKE(cir),
    .SYSTEM_POWER_REQUEST_N(req_n), .IRQ(irq));
  spw_src spw_src_inst (.SYS_CLK(clk), .FIRE(fire), .PINS(pins), .ALARM(alarm), .CIR(cir));
  initial forever #20 clk = ~clk;
  initial begin
    repeat (4000) @(posedge clk);
    err_total++;
    close_out();
  end
  // ==========================================================================
  // tasks
  task automatic close_out();
    if (err_total == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] i, input logic [7:0] d);
    haddr <= {22'h0, i, 2'b00};
    htrans <= HTRANS_NSQ;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge clk); while (hready !== 1'b1);
    rv = hrdata;
  endtask
  task automatic rd(input logic [7:0] i, input logic [7:0] e);
    ahb(1'b0, i, 8'h00);
    chk(rv, {24'h0, e});
    chk({31'h0, hresp}, 32'h0);
  endtask
  task automatic pulse(input logic [10:0] m);
    fire <= m;
    @(posedge clk);
    fire <= 11'h0;
    repeat (10) @(posedge clk);
  endtask
  task automatic look(input logic e_req, input logic e_irq);
    @(negedge clk);
    chk({30'h0, req_n, irq}, {30'h0, e_req, e_irq});
    @(posedge clk);
  endtask
  // ==========================================================================
  // main sequence
  initial begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rd(EN1_IDX, EN1_RST);
    rd(EN2_IDX, EN2_RST);
    rd(STS1_IDX, STS_RST);
    rd(STS2_IDX, STS_RST);
    rd(MASK1_IDX, MASK_RST);
    rd(8'hff, 8'h00);
    ahb(1'b1, EN1_IDX, 8'hff);
    ahb(1'b1, EN2_IDX, 8'hff);
    rd(EN1_IDX, 8'hff);
    look(1'b1, 1'b0);
    for (int i = 0; i < 11; i++) begin
      ri = rsel[i] ? STS2_IDX : STS1_IDX;
      pulse(11'h1 << i);
      look(rreq[i], 1'b0);
      rd(ri, rexp[i]);
      rd(ri, 8'h00);
      look(1'b1, 1'b0);
    end
    ahb(1'b1, EN1_IDX, 8'h00);
    ahb(1'b1, EN2_IDX, 8'h00);
    pulse(11'h060);
    ahb(1'b1, STS2_IDX, 8'h00);
    look(1'b1, 1'b0);
    rd(STS2_IDX, 8'h03);
    g1 <= 1'b1;
    @(posedge clk);
    rd(STS1_IDX, 8'h10);
    rd(STS1_IDX, 8'h10);
    g1 <= 1'b0;
    g2 <= 1'b1;
    @(posedge clk);
    rd(STS1_IDX, 8'h20);
    g2 <= 1'b0;
    @(posedge clk);
    rd(STS1_IDX, 8'h00);
    rd(ISTS1_IDX, 8'hff);
    rd(ISTS2_IDX, 8'h2f);
    rd(ISTS1_IDX, 8'h00);
    ahb(1'b1, MASK1_IDX, 8'h01);
    pulse(11'h004);
    look(1'b1, 1'b0);
    pulse(11'h001);
    look(1'b1, 1'b1);
    rd(ISTS1_IDX, 8'h05);
    rd(STS1_IDX, 8'h05);
    look(1'b1, 1'b0);
    ahb(1'b1, MASK2_IDX, 8'h01);
    rd(MASK2_IDX, 8'h01);
    pulse(11'h020);
    look(1'b1, 1'b1);
    rd(ISTS2_IDX, 8'h01);
    look(1'b1, 1'b0);
    ahb(1'b1, EN1_IDX, 8'h10);
    g1 <= 1'b1;
    repeat (2) @(posedge clk);
    look(1'b0, 1'b0);
    g1 <= 1'b0;
    @(posedge clk);
    look(1'b1, 1'b0);
    close_out();
  end
endmodule // soft_power_wake_status_test
bind spw_wake_status spw_chk spw_chk_inst (.*);
